//--- logic/schbp_defines.vh
// constants for the serial controller host bus port
`ifndef SCHBP_DEFINES_VH
`define SCHBP_DEFINES_VH
`define SCHBP_REG_VECTOR   4'h2
`define SCHBP_REG_EXT      4'h7
`define SCHBP_REG_TXFIFO   4'h8
`define SCHBP_REG_MASTER   4'h9
`define SCHBP_REG_EXTINT   4'hf
`define SCHBP_REG_CNTLO    4'h6
`define SCHBP_REG_CNTHI    4'h7
`define SCHBP_BIT_EXT_EN   0
`define SCHBP_BIT_CNT_EN   2
`define SCHBP_BIT_MIRROR   6
`define SCHBP_TX_DEPTH     4
`define SCHBP_TX_AW        2
`define SCHBP_RX_DEPTH     8
`define SCHBP_RX_AW        3
`define SCHBP_REG_RESET    8'h00
`endif

//--- logic/schbp_fifo.v
// small synchronous byte fifo used for transmit and receive data
`timescale 1ns/1ns
module schbp_fifo #(
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire       ref_clk_in,
	input  wire       rst_in,
	input  wire       clr_in,
	input  wire       wr_in,
	input  wire [7:0] wdata_in,
	input  wire       rd_in,
	output wire [7:0] rdata_out,
	output wire       full_out,
	output wire       empty_out
);
	reg [7:0]  mem [0:DEPTH-1];
	reg [AW-1:0] wp_ff;
	reg [AW-1:0] rp_ff;
	reg [AW:0]   cnt_ff;
	wire do_wr = wr_in && !full_out;
	wire do_rd = rd_in && !empty_out;
	assign full_out  = (cnt_ff == DEPTH[AW:0]);
	assign empty_out = (cnt_ff == {(AW+1){1'b0}});
	assign rdata_out = mem[rp_ff];
	always @(posedge ref_clk_in) begin
		if (do_wr)
			mem[wp_ff] <= wdata_in;
	end
	always @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			wp_ff  <= {AW{1'b0}};
			rp_ff  <= {AW{1'b0}};
			cnt_ff <= {(AW+1){1'b0}};
		end else if (clr_in) begin
			wp_ff  <= {AW{1'b0}};
			rp_ff  <= {AW{1'b0}};
			cnt_ff <= {(AW+1){1'b0}};
		end else begin
			if (do_wr)
				wp_ff <= wp_ff + {{(AW-1){1'b0}}, 1'b1};
			if (do_rd)
				rp_ff <= rp_ff + {{(AW-1){1'b0}}, 1'b1};
			if (do_wr && !do_rd)
				cnt_ff <= cnt_ff + {{AW{1'b0}}, 1'b1};
			else if (do_rd && !do_wr)
				cnt_ff <= cnt_ff - {{AW{1'b0}}, 1'b1};
		end
	end
endmodule // schbp_fifo

//--- logic/schbp_port.v
// host bus port: strobe and multiplexed variants, register file, data fifos
`timescale 1ns/1ns
`include "schbp_defines.vh"
module schbp_port (
	input  wire       ref_clk_in,
	input  wire       rst_in,
	input  wire       mux_mode_in,
	input  wire       chip_enable_n_in,
	input  wire       read_n_in,
	input  wire       write_n_in,
	input  wire       chan_a_sel_in,
	input  wire       data_sel_in,
	input  wire [7:0] host_data_bus_in,
	output reg  [7:0] host_data_bus_out,
	output reg        host_data_bus_oe_out,
	input  wire [7:0] muxed_addr_data_bus_in,
	output reg  [7:0] muxed_addr_data_bus_out,
	output reg        muxed_addr_data_bus_oe_out,
	input  wire       read_not_write_in,
	input  wire       latched_chip_select_n_in,
	input  wire       qualifying_chip_select_in,
	input  wire       address_strobe_n_in,
	input  wire       data_strobe_n_in,
	input  wire       interrupt_acknowledge_n_in,
	input  wire       int_enable_in_in,
	input  wire       int_request_in,
	input  wire [2:0] vector_status_in,
	input  wire [7:0] rr_status_a_in,
	input  wire [7:0] rr_status_b_in,
	input  wire [15:0] frame_count_a_in,
	input  wire [15:0] frame_count_b_in,
	input  wire [7:0] rx_push_a_data_in,
	input  wire       rx_push_a_in,
	input  wire [7:0] rx_push_b_data_in,
	input  wire       rx_push_b_in,
	input  wire       tx_pop_a_in,
	input  wire       tx_pop_b_in,
	output reg  [7:0] tx_data_a_out,
	output reg  [7:0] tx_data_b_out,
	output reg        tx_empty_a_out,
	output reg        tx_empty_b_out,
	output reg        tx_full_a_out,
	output reg        tx_full_b_out,
	output reg        rx_full_a_out,
	output reg        rx_full_b_out,
	output reg        dev_reset_out,
	output reg  [7:0] master_ctl_out
);
	// ==========================================================
	// synchronisers
	localparam NS = 10;
	wire [NS-1:0] raw = {mux_mode_in, chip_enable_n_in, read_n_in, write_n_in,
		chan_a_sel_in, data_sel_in, read_not_write_in, qualifying_chip_select_in,
		address_strobe_n_in, data_strobe_n_in};
	reg [NS-1:0] s1_ff;
	reg [NS-1:0] s2_ff;
	reg [7:0]    bus1_ff;
	reg [7:0]    bus2_ff;
	reg [7:0]    mbus1_ff;
	reg [7:0]    mbus2_ff;
	reg          lcs_1_ff;
	reg          lcs_2_ff;
	reg          ack1_ff;
	reg          ack2_ff;
	always @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			s1_ff    <= {NS{1'b1}};
			s2_ff    <= {NS{1'b1}};
			bus1_ff  <= 8'h00;
			bus2_ff  <= 8'h00;
			mbus1_ff <= 8'h00;
			mbus2_ff <= 8'h00;
			lcs_1_ff <= 1'b1;
			lcs_2_ff <= 1'b1;
			ack1_ff  <= 1'b1;
			ack2_ff  <= 1'b1;
		end else begin
			s1_ff    <= raw;
			s2_ff    <= s1_ff;
			bus1_ff  <= host_data_bus_in;
			bus2_ff  <= bus1_ff;
			mbus1_ff <= muxed_addr_data_bus_in;
			mbus2_ff <= mbus1_ff;
			lcs_1_ff <= latched_chip_select_n_in;
			lcs_2_ff <= lcs_1_ff;
			ack1_ff  <= interrupt_acknowledge_n_in;
			ack2_ff  <= ack1_ff;
		end
	end
	wire mux_s = s2_ff[9];
	wire ce_n  = s2_ff[8];
	wire rd_n  = s2_ff[7];
	wire wr_n  = s2_ff[6];
	wire cha_s = s2_ff[5];
	wire dat_s = s2_ff[4];
	wire rnw_s = s2_ff[3];
	wire qcs_s = s2_ff[2];
	wire as_n  = s2_ff[1];
	wire dsb_n = s2_ff[0];
	wire ack_n = ack2_ff;

	// ==========================================================
	// access decode
	reg        as_d_ff;
	reg        mux_cha_ff;
	reg        mux_sel_ff;
	reg [3:0]  mux_addr_ff;
	reg [3:0]  ptr_ff;
	reg        act_d_ff;
	wire strobe_rst = mux_s ? (!as_n && !dsb_n) : (!rd_n && !wr_n);
	// strobe variant: chip enable qualifies both strobes
	wire s_rd  = !mux_s && !ce_n && !rd_n && wr_n;
	wire s_wr  = !mux_s && !ce_n && !wr_n && rd_n;
	// muxed variant: latched select plus live qualifying select
	wire m_sel = mux_s && mux_sel_ff && qcs_s && !dsb_n && as_n;
	wire m_rd  = m_sel && rnw_s;
	wire m_wr  = m_sel && !rnw_s;
	wire act   = s_rd || s_wr || m_rd || m_wr;
	wire start = act && !act_d_ff && !strobe_rst;
	wire is_rd = s_rd || m_rd;
	wire chan_a = mux_s ? mux_cha_ff : cha_s;
	// strobe variant: data select picks the fifo port, else pointer register
	wire [3:0] addr = mux_s ? mux_addr_ff :
		(dat_s ? `SCHBP_REG_TXFIFO : ptr_ff);
	wire ack_hit = !ack_n && int_enable_in_in && int_request_in;

	always @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			as_d_ff     <= 1'b1;
			mux_cha_ff  <= 1'b1;
			mux_sel_ff  <= 1'b0;
			mux_addr_ff <= 4'h0;
			act_d_ff    <= 1'b0;
		end else begin
			as_d_ff  <= as_n;
			act_d_ff <= act;
			if (as_n && !as_d_ff && dsb_n) begin
				mux_addr_ff <= mbus2_ff[3:0];
				mux_cha_ff  <= mbus2_ff[4];
				mux_sel_ff  <= !lcs_2_ff;
			end
		end
	end

	// ==========================================================
	// register file
	reg [7:0] wr_a_ff [0:15];
	reg [7:0] wr_b_ff [0:15];
	reg [7:0] ext_a_ff;
	reg [7:0] ext_b_ff;
	reg [7:0] vector_write_reg_ff;
	reg [7:0] master_interrupt_reset_reg_ff;
	wire [7:0] eic = chan_a ? wr_a_ff[`SCHBP_REG_EXTINT] : wr_b_ff[`SCHBP_REG_EXTINT];
	wire [7:0] ext = chan_a ? ext_a_ff : ext_b_ff;
	wire ext_sel = eic[`SCHBP_BIT_EXT_EN] && (addr == `SCHBP_REG_EXT);
	wire wr_go = start && !is_rd && !ack_hit;
	wire rd_go = start && is_rd && !ack_hit;
	wire tx_push = wr_go && (addr == `SCHBP_REG_TXFIFO);
	wire rx_pop  = rd_go && (addr == `SCHBP_REG_TXFIFO);
	wire [7:0] wbyte = mux_s ? mbus2_ff : bus2_ff;
	integer i;
	always @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			for (i = 0; i < 16; i = i + 1) begin
				wr_a_ff[i] <= `SCHBP_REG_RESET;
				wr_b_ff[i] <= `SCHBP_REG_RESET;
			end
			ext_a_ff <= `SCHBP_REG_RESET;
			ext_b_ff <= `SCHBP_REG_RESET;
			vector_write_reg_ff <= `SCHBP_REG_RESET;
			master_interrupt_reset_reg_ff <= `SCHBP_REG_RESET;
			ptr_ff <= 4'h0;
		end else if (strobe_rst) begin
			ptr_ff <= 4'h0;
		end else begin
			if (!mux_s && start && !dat_s)
				ptr_ff <= (!is_rd && ptr_ff == 4'h0) ? bus2_ff[3:0] : 4'h0;
			if (wr_go && !(!mux_s && !dat_s && ptr_ff == 4'h0)) begin
				if (ext_sel) begin
					if (chan_a)
						ext_a_ff <= wbyte;
					else
						ext_b_ff <= wbyte;
				end else if (addr == `SCHBP_REG_VECTOR)
					vector_write_reg_ff <= wbyte;
				else if (addr == `SCHBP_REG_MASTER)
					master_interrupt_reset_reg_ff <= wbyte;
				else if (chan_a)
					wr_a_ff[addr] <= wbyte;
				else
					wr_b_ff[addr] <= wbyte;
			end
		end
	end

	// ==========================================================
	// data fifos
	wire [7:0] txd_a;
	wire [7:0] txd_b;
	wire [7:0] rxd_a;
	wire [7:0] rxd_b;
	wire       txe_a;
	wire       txe_b;
	wire       txf_a;
	wire       txf_b;
	wire       rxe_a;
	wire       rxe_b;
	wire       rxf_a;
	wire       rxf_b;
	wire [15:0] txd_v;
	wire [15:0] rxd_v;
	wire [1:0]  txe_v;
	wire [1:0]  txf_v;
	wire [1:0]  rxe_v;
	wire [1:0]  rxf_v;
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : gch
			wire sel = (g == 0) ? chan_a : !chan_a;
			schbp_fifo #(.DEPTH(`SCHBP_TX_DEPTH), .AW(`SCHBP_TX_AW)) u_tx (
				.ref_clk_in (ref_clk_in),
				.rst_in     (rst_in),
				.clr_in     (strobe_rst),
				.wr_in      (tx_push && sel),
				.wdata_in   (wbyte),
				.rd_in      ((g == 0) ? tx_pop_a_in : tx_pop_b_in),
				.rdata_out  (txd_v[g*8 +: 8]),
				.full_out   (txf_v[g]),
				.empty_out  (txe_v[g])
			);
			schbp_fifo #(.DEPTH(`SCHBP_RX_DEPTH), .AW(`SCHBP_RX_AW)) u_rx (
				.ref_clk_in (ref_clk_in),
				.rst_in     (rst_in),
				.clr_in     (strobe_rst),
				.wr_in      ((g == 0) ? rx_push_a_in : rx_push_b_in),
				.wdata_in   ((g == 0) ? rx_push_a_data_in : rx_push_b_data_in),
				.rd_in      (rx_pop && sel),
				.rdata_out  (rxd_v[g*8 +: 8]),
				.full_out   (rxf_v[g]),
				.empty_out  (rxe_v[g])
			);
		end
	endgenerate
	assign txd_a = txd_v[7:0];
	assign txd_b = txd_v[15:8];
	assign txe_a = txe_v[0];
	assign txe_b = txe_v[1];
	assign txf_a = txf_v[0];
	assign txf_b = txf_v[1];
	assign rxd_a = rxd_v[7:0];
	assign rxd_b = rxd_v[15:8];
	assign rxe_a = rxe_v[0];
	assign rxe_b = rxe_v[1];
	assign rxf_a = rxf_v[0];
	assign rxf_b = rxf_v[1];

	// ==========================================================
	// read mux
	function is_mirror;
		input [3:0] a;
		begin
			is_mirror = (a == 4'h4) || (a == 4'h5) || (a == 4'h9) ||
				(a == 4'hb) || (a == 4'he) || (a == 4'hf);
		end
	endfunction
	reg [7:0] rdata;
	always @* begin
		rdata = 8'h00;
		if (ack_hit)
			rdata = {vector_write_reg_ff[7:4], vector_status_in, vector_write_reg_ff[0]};
		else if (ext[`SCHBP_BIT_MIRROR] && is_mirror(addr)) begin
			if (addr == `SCHBP_REG_MASTER)
				rdata = master_interrupt_reset_reg_ff;
			else
				rdata = chan_a ? wr_a_ff[addr] : wr_b_ff[addr];
		end else if (addr == `SCHBP_REG_VECTOR)
			rdata = chan_a ? vector_write_reg_ff :
				{vector_write_reg_ff[7:4], vector_status_in, vector_write_reg_ff[0]};
		else if (eic[`SCHBP_BIT_CNT_EN] && addr == `SCHBP_REG_CNTLO)
			rdata = chan_a ? frame_count_a_in[7:0] : frame_count_b_in[7:0];
		else if (eic[`SCHBP_BIT_CNT_EN] && addr == `SCHBP_REG_CNTHI)
			rdata = chan_a ? {rxf_a, rxe_a, frame_count_a_in[13:8]} :
				{rxf_b, rxe_b, frame_count_b_in[13:8]};
		else if (addr == `SCHBP_REG_TXFIFO)
			rdata = chan_a ? rxd_a : rxd_b;
		else if (addr == 4'hc || addr == 4'hd)
			rdata = chan_a ? wr_a_ff[addr] : wr_b_ff[addr];
		else
			rdata = chan_a ? rr_status_a_in : rr_status_b_in;
	end

	// ==========================================================
	// registered outputs; read data held until strobe drops
	always @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			host_data_bus_out          <= 8'h00;
			host_data_bus_oe_out       <= 1'b0;
			muxed_addr_data_bus_out    <= 8'h00;
			muxed_addr_data_bus_oe_out <= 1'b0;
			tx_data_a_out  <= 8'h00;
			tx_data_b_out  <= 8'h00;
			tx_empty_a_out <= 1'b1;
			tx_empty_b_out <= 1'b1;
			tx_full_a_out  <= 1'b0;
			tx_full_b_out  <= 1'b0;
			rx_full_a_out  <= 1'b0;
			rx_full_b_out  <= 1'b0;
			dev_reset_out  <= 1'b0;
			master_ctl_out <= 8'h00;
		end else begin
			if (start && is_rd)
				host_data_bus_out <= rdata;
			if (start && is_rd)
				muxed_addr_data_bus_out <= rdata;
			host_data_bus_oe_out       <= s_rd && !strobe_rst;
			muxed_addr_data_bus_oe_out <= m_rd && !strobe_rst;
			tx_data_a_out  <= txd_a;
			tx_data_b_out  <= txd_b;
			tx_empty_a_out <= txe_a;
			tx_empty_b_out <= txe_b;
			tx_full_a_out  <= txf_a;
			tx_full_b_out  <= txf_b;
			rx_full_a_out  <= rxf_a;
			rx_full_b_out  <= rxf_b;
			dev_reset_out  <= strobe_rst;
			master_ctl_out <= master_interrupt_reset_reg_ff;
		end
	end
endmodule // schbp_port

//--- test/schbp_host.sv
// host model driving the strobe and multiplexed bus variants
`timescale 1ns/1ns
module schbp_host (
	input  wire       ref_clk_in,
	output reg        mux_out,
	output reg        ce_n_out,
	output reg        rd_n_out,
	output reg        wr_n_out,
	output reg        ab_out,
	output reg        dc_out,
	output reg  [7:0] bus_out,
	output reg        rnw_out,
	output reg        lcs_n_out,
	output reg        qcs_out,
	output reg        as_n_out,
	output reg        dsb_n_out
);
	initial begin
		{mux_out, ab_out, dc_out, rnw_out, qcs_out, bus_out} = 13'h0;
		{ce_n_out, rd_n_out, wr_n_out, lcs_n_out, as_n_out, dsb_n_out} = 6'h3f;
	end
	task cyc(input integer n);
		repeat (n) @(posedge ref_clk_in);
	endtask
	// ========
	// strobe variant; each phase held 4 cycles to clear the sync stages
	task sacc(input rd, input ce, input a, input d, input [7:0] v);
		cyc(1);
		ce_n_out <= !ce;
		ab_out <= a;
		dc_out <= d;
		bus_out <= v;
		rd_n_out <= !rd;
		wr_n_out <= rd;
		cyc(4);
		{ce_n_out, rd_n_out, wr_n_out} <= 3'h7;
		bus_out <= ~v; // released bus must not look like stale data
		cyc(4);
	endtask
	// ========
	// multiplexed variant: address phase, then data phase
	task macc(input rd, input sel, input [7:0] adr, input [7:0] v);
		cyc(1);
		qcs_out <= 1'b1;
		lcs_n_out <= !sel;
		rnw_out <= rd;
		bus_out <= adr;
		as_n_out <= 1'b0;
		cyc(4);
		as_n_out <= 1'b1;
		cyc(4);
		bus_out <= rd ? ~adr : v;
		dsb_n_out <= 1'b0;
		cyc(4);
		{dsb_n_out, qcs_out, lcs_n_out} <= 3'h5;
		bus_out <= ~v;
		cyc(4);
	endtask
	// both strobes low together only when a reset is wanted
	task combo(input m);
		cyc(1);
		if (m) {as_n_out, dsb_n_out} <= 2'h0;
		else {ce_n_out, rd_n_out, wr_n_out} <= 3'h0;
		cyc(4);
		{ce_n_out, rd_n_out, wr_n_out, as_n_out, dsb_n_out} <= 5'h1f;
		cyc(4);
	endtask
	task mode(input m);
		cyc(1);
		mux_out <= m;
		cyc(4);
	endtask
endmodule // schbp_host

//--- test/schbp_port_bench.sv
// self-checking bench for the host bus port
`timescale 1ns/1ns
module schbp_port_bench;
	reg         ref_clk_in, rst_in, interrupt_acknowledge_n_in, int_enable_in_in, int_request_in;
	wire        mux_mode_in, chip_enable_n_in, read_n_in, write_n_in, chan_a_sel_in;
	wire        data_sel_in, read_not_write_in, latched_chip_select_n_in;
	wire        qualifying_chip_select_in, address_strobe_n_in, data_strobe_n_in;
	wire [7:0]  host_data_bus_in, muxed_addr_data_bus_in, host_data_bus_out, master_ctl_out;
	wire [7:0]  muxed_addr_data_bus_out, tx_data_a_out, tx_data_b_out;
	reg  [2:0]  vector_status_in;
	reg  [7:0]  rr_status_a_in, rr_status_b_in, rx_push_a_data_in, rx_push_b_data_in;
	reg  [15:0] frame_count_a_in, frame_count_b_in;
	reg         rx_push_a_in, rx_push_b_in, tx_pop_a_in, tx_pop_b_in, oe_q;
	wire        host_data_bus_oe_out, muxed_addr_data_bus_oe_out, tx_empty_a_out;
	wire        tx_empty_b_out, tx_full_a_out, tx_full_b_out, rx_full_a_out, rx_full_b_out;
	wire        dev_reset_out;
	integer     fails, n_checks, seed, i;
	reg  [7:0]  v, exp_q[$], tb[0:3];
	wire        oe = host_data_bus_oe_out | muxed_addr_data_bus_oe_out;
	wire [7:0]  rb = mux_mode_in ? muxed_addr_data_bus_out : host_data_bus_out;
	assign muxed_addr_data_bus_in = host_data_bus_in;
	schbp_port uut (.*);
	schbp_host host (
		.ref_clk_in(ref_clk_in), .mux_out(mux_mode_in), .ce_n_out(chip_enable_n_in),
		.rd_n_out(read_n_in), .wr_n_out(write_n_in), .ab_out(chan_a_sel_in), .dc_out(data_sel_in),
		.bus_out(host_data_bus_in), .rnw_out(read_not_write_in),
		.lcs_n_out(latched_chip_select_n_in), .qcs_out(qualifying_chip_select_in),
		.as_n_out(address_strobe_n_in), .dsb_n_out(data_strobe_n_in)
	);
	initial ref_clk_in = 1'b0;
	always #5 ref_clk_in = ~ref_clk_in;
	task chk(input [7:0] got, input [7:0] exp);
		n_checks = n_checks + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task creg(input rd, input a, input [3:0] r, input [7:0] d);
		host.sacc(1'b0, 1'b1, a, 1'b0, {4'h0, r});
		host.sacc(rd, 1'b1, a, 1'b0, d);
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// ========
	// read monitor: every bus turn-on consumes the oldest expectation
	always @(posedge ref_clk_in) begin
		oe_q <= oe;
		if (oe && !oe_q) begin
			if (exp_q.size() == 0) chk(8'h00, 8'h01);
			else chk(rb, exp_q.pop_front());
		end
	end
	initial begin
		#100000;
		fails = fails + 1;
		$display("CHECK FAILED at %0t: run did not finish", $time);
		close_out;
	end
	// ========
	// main sequence
	initial begin
		seed = 32'hbe62e18b;
		{fails, n_checks} = 0;
		rst_in = 1'b1;
		{interrupt_acknowledge_n_in, int_enable_in_in, int_request_in} = 3'h4;
		{rx_push_a_in, rx_push_b_in, tx_pop_a_in, tx_pop_b_in} = 4'h0;
		{rx_push_a_data_in, rx_push_b_data_in} = 16'h0;
		vector_status_in = $random(seed);
		{rr_status_a_in, rr_status_b_in} = $random(seed);
		{frame_count_a_in, frame_count_b_in} = $random(seed);
		repeat (5) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		repeat (3) @(posedge ref_clk_in);
		chk({7'h0, tx_empty_a_out}, 8'h01);
		chk(master_ctl_out, 8'h00);
		chk({4'h0, tx_empty_b_out, tx_full_a_out, tx_full_b_out, rx_full_a_out}, 8'h08);
		for (i = 0; i < 2; i = i + 1) begin
			v = $random(seed);
			creg(1'b0, i[0], 4'h9, v);
			chk(master_ctl_out, v);
		end
		host.sacc(1'b0, 1'b0, 1'b1, 1'b0, 8'h09);
		host.sacc(1'b0, 1'b0, 1'b1, 1'b0, 8'hff);
		host.sacc(1'b1, 1'b0, 1'b1, 1'b0, 8'h00);
		chk(master_ctl_out, v);
		$display("test done: master and select");
		v = $random(seed);
		creg(1'b0, 1'b0, 4'h2, v);
		exp_q.push_back(v);
		creg(1'b1, 1'b1, 4'h2, 8'h00);
		exp_q.push_back({v[7:4], vector_status_in, v[0]});
		creg(1'b1, 1'b0, 4'h2, 8'h00);
		exp_q.push_back(rr_status_a_in);
		host.sacc(1'b1, 1'b1, 1'b1, 1'b0, 8'h00);
		// acknowledge read with the chain enabled returns the vector
		exp_q.push_back({v[7:4], vector_status_in, v[0]});
		{interrupt_acknowledge_n_in, int_enable_in_in, int_request_in} <= 3'h3;
		host.sacc(1'b1, 1'b1, 1'b1, 1'b0, 8'h00);
		// a higher device holds the chain: ordinary register read
		exp_q.push_back(rr_status_a_in);
		{interrupt_acknowledge_n_in, int_enable_in_in, int_request_in} <= 3'h1;
		host.sacc(1'b1, 1'b1, 1'b1, 1'b0, 8'h00);
		{interrupt_acknowledge_n_in, int_enable_in_in, int_request_in} <= 3'h4;
		creg(1'b0, 1'b1, 4'hf, 8'h05);
		creg(1'b0, 1'b1, 4'h7, 8'h40);
		v = $random(seed);
		creg(1'b0, 1'b1, 4'h4, v);
		exp_q.push_back(v);
		creg(1'b1, 1'b1, 4'h4, 8'h00);
		exp_q.push_back(8'h05);
		creg(1'b1, 1'b1, 4'hf, 8'h00);
		exp_q.push_back(frame_count_a_in[7:0]);
		creg(1'b1, 1'b1, 4'h6, 8'h00);
		exp_q.push_back({2'h1, frame_count_a_in[13:8]});
		creg(1'b1, 1'b1, 4'h7, 8'h00);
		$display("test done: vector, mirror, count");
		for (i = 0; i < 4; i = i + 1) begin
			tb[i] = $random(seed);
			host.sacc(1'b0, 1'b1, 1'b1, 1'b1, tb[i]);
		end
		chk({7'h0, tx_full_a_out}, 8'h01);
		for (i = 0; i < 4; i = i + 1) begin
			chk(tx_data_a_out, tb[i]);
			tx_pop_a_in <= 1'b1;
			@(posedge ref_clk_in);
			tx_pop_a_in <= 1'b0;
			repeat (3) @(posedge ref_clk_in);
		end
		chk({7'h0, tx_empty_a_out}, 8'h01);
		host.sacc(1'b0, 1'b1, 1'b0, 1'b1, v);
		chk(tx_data_b_out, v);
		chk({6'h0, tx_empty_b_out, tx_full_b_out}, 8'h00);
		for (i = 0; i < 8; i = i + 1) begin
			v = $random(seed);
			exp_q.push_back(v);
			rx_push_b_data_in <= v;
			rx_push_b_in <= 1'b1;
			@(posedge ref_clk_in);
		end
		rx_push_b_in <= 1'b0;
		repeat (2) @(posedge ref_clk_in);
		chk({7'h0, rx_full_b_out}, 8'h01);
		for (i = 0; i < 8; i = i + 1) host.sacc(1'b1, 1'b1, 1'b0, 1'b1, 8'h00);
		$display("test done: fifos");
		host.sacc(1'b0, 1'b1, 1'b1, 1'b1, 8'h5a);
		host.combo(1'b0);
		chk({7'h0, tx_empty_a_out}, 8'h01);
		chk({7'h0, tx_empty_b_out}, 8'h01);
		host.mode(1'b1);
		v = $random(seed);
		host.macc(1'b0, 1'b1, 8'h12, v);
		host.macc(1'b0, 1'b0, 8'h12, ~v);
		exp_q.push_back(v);
		host.macc(1'b1, 1'b1, 8'h12, 8'h00);
		host.macc(1'b0, 1'b1, 8'h18, v);
		chk({7'h0, tx_empty_a_out}, 8'h00);
		host.combo(1'b1);
		chk({7'h0, tx_empty_a_out}, 8'h01);
		chk({7'h0, exp_q.size() == 0}, 8'h01);
		$display("test done: reset and muxed");
		close_out;
	end
endmodule // schbp_port_bench

//--- test/schbp_port_chk.sv
// assertion checker for the host bus port
`timescale 1ns/1ns
module schbp_port_chk (
	input wire ref_clk_in,
	input wire rst_in,
	input wire mux_mode_in,
	input wire chip_enable_n_in,
	input wire read_n_in,
	input wire write_n_in,
	input wire read_not_write_in,
	input wire address_strobe_n_in,
	input wire data_strobe_n_in,
	input wire host_data_bus_oe_out,
	input wire muxed_addr_data_bus_oe_out,
	input wire tx_empty_a_out,
	input wire dev_reset_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	sequence s_srd;
		!mux_mode_in && !chip_enable_n_in && !read_n_in && write_n_in;
	endsequence
	sequence s_sres;
		!mux_mode_in && !read_n_in && !write_n_in;
	endsequence
	sequence s_mres;
		mux_mode_in && !address_strobe_n_in && !data_strobe_n_in;
	endsequence
	rd_drive_a: assert property (
		$rose(host_data_bus_oe_out) |-> !$past(chip_enable_n_in, 3) && !$past(read_n_in, 3))
		else $error("bus driven without a selected read");
	rd_timing_a: assert property (s_srd[*4] |-> host_data_bus_oe_out)
		else $error("read not answered in 3 cycles");
	no_select_a: assert property (chip_enable_n_in[*4] |-> !host_data_bus_oe_out)
		else $error("bus driven while not selected");
	rd_release_a: assert property (
		$rose(read_n_in) && !mux_mode_in |-> ##3 !host_data_bus_oe_out)
		else $error("bus not released after read");
	strobe_reset_a: assert property (s_sres[*4] |-> dev_reset_out)
		else $error("strobe reset not seen");
	mux_reset_a: assert property (s_mres[*4] |-> dev_reset_out)
		else $error("muxed reset not seen");
	mux_drive_a: assert property (
		$rose(muxed_addr_data_bus_oe_out) |->
		!$past(data_strobe_n_in, 3) && $past(read_not_write_in, 3))
		else $error("muxed bus driven outside a read data phase");
	reset_clear_a: assert property ($rose(dev_reset_out) |-> ##[1:3] tx_empty_a_out)
		else $error("reset left transmit data behind");
endmodule // schbp_port_chk
bind schbp_port schbp_port_chk chk_i (
	.ref_clk_in(ref_clk_in), .rst_in(rst_in), .mux_mode_in(mux_mode_in),
	.chip_enable_n_in(chip_enable_n_in), .read_n_in(read_n_in), .write_n_in(write_n_in),
	.read_not_write_in(read_not_write_in), .address_strobe_n_in(address_strobe_n_in),
	.data_strobe_n_in(data_strobe_n_in), .host_data_bus_oe_out(host_data_bus_oe_out),
	.muxed_addr_data_bus_oe_out(muxed_addr_data_bus_oe_out),
	.tx_empty_a_out(tx_empty_a_out), .dev_reset_out(dev_reset_out)
);
